// [core/elc_loop.sv]
// Error converter control, three-pole loop compensator and command scaling
`timescale 1ns/10ps
module elc_loop
  import elc_pkg::*;
(
  // Modulator clock domain and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  // Modulator sample request and converter interface
  input  wire logic                          i_sample_req,
  output logic                               o_conv_start,
  input  wire logic                          i_conv_done,
  input  wire logic [elc_pkg::THERM_W-1:0]   i_conv_therm,
  output logic      [elc_pkg::REF_W-1:0]     o_err_ref,
  output logic      [elc_pkg::GAIN_W-1:0]    o_afe_gain,
  // Configuration
  input  wire logic                          i_filter_en,
  input  wire logic [elc_pkg::REF_W-1:0]     i_err_ref,
  input  wire logic [elc_pkg::GAIN_W-1:0]    i_afe_gain,
  input  wire elc_pkg::elc_mode_t            i_mode,
  input  wire logic [elc_pkg::PRD_W-1:0]     i_switching_period,
  input  wire logic [elc_pkg::PRD_W-1:0]     i_maximum_period,
  input  wire logic [elc_pkg::PCT_W-1:0]     i_fixed_duty_percentage,
  input  wire logic [elc_pkg::PCT_W-1:0]     i_clamp_min,
  input  wire logic [elc_pkg::PCT_W-1:0]     i_clamp_max,
  // Coefficient banks
  input  wire logic                          i_bank_sel,
  input  wire logic                          i_coef_we,
  input  wire logic                          i_coef_bank,
  input  wire logic [2:0]                    i_coef_idx,
  input  wire logic [elc_pkg::COEF_W-1:0]    i_coef_data,
  input  wire logic [elc_pkg::SHIFT_W-1:0]   i_coef_shift,
  // Status
  output logic                               o_bank_active,
  output logic      [elc_pkg::ERR_W-1:0]     o_err_sample,
  output logic      [elc_pkg::STATE_W-1:0]   o_per_unit_command,
  // Command stream to the modulator
  output logic                               o_cmd_valid,
  input  wire logic                          i_cmd_ready,
  output logic      [elc_pkg::DUTY_W-1:0]    o_duty_command,
  output logic      [elc_pkg::PRD_W-1:0]     o_period_command,
  output elc_pkg::elc_mode_t                 o_cmd_mode
);
  import elc_pkg::*;

  localparam int CMD_W = DUTY_W + PRD_W + 2;

  // Saturate a wide signed value into a 16-bit Q15 per-unit range
  function automatic logic [STATE_W-1:0] sat_pu(input logic signed [ACC_W-1:0] v);
    if (v < 0)
      sat_pu = '0;
    else if (v > $signed({{(ACC_W-STATE_W){1'b0}}, PU_ONE}))
      sat_pu = PU_ONE;
    else
      sat_pu = v[STATE_W-1:0];
  endfunction

  // Q15 fraction times a 14-bit count, kept with 4 fine bits
  function automatic logic [DUTY_W-1:0] scale(input logic [STATE_W-1:0] pu,
                                              input logic [PRD_W-1:0] switching_period);
    logic [STATE_W+PRD_W-1:0] p;
    p = pu * switching_period;
    scale = p[PU_FRAC-FINE_W +: DUTY_W];
  endfunction

  // Data clock enable from the modulator clock
  logic [DIV_W-1:0] div_reg;
  wire              loop_data_clock_tick = (div_reg == DIV_LAST);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= '0;
    else
      div_reg <= div_reg + 3'h1;
  end

  // Thermometer decode: popcount minus mid-scale
  logic [ERR_W:0] ones;
  always_comb
  begin
    ones = '0;
    for (int i = 0; i < THERM_W; i++)
      ones = ones + {{ERR_W{1'b0}}, i_conv_therm[i]};
  end
  wire [ERR_W-1:0] err_code = ones[ERR_W-1:0] - 6'h20;

  assign o_err_ref  = i_err_ref;
  assign o_afe_gain = i_afe_gain;

  // Sequencer
  elc_state_t st_reg;
  elc_state_t st_next;
  logic       req_pend_reg;
  logic [2:0] step_reg;
  logic       buf_ready;
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (loop_data_clock_tick && req_pend_reg && i_filter_en) st_next = ST_CONV;
      ST_CONV: if (i_conv_done) st_next = ST_FILT;
      ST_FILT: if (loop_data_clock_tick && step_reg == 3'h2) st_next = ST_OUT;
      ST_OUT:  if (buf_ready) st_next = ST_IDLE;
    endcase
  end
  assign o_conv_start = (st_reg == ST_IDLE) && loop_data_clock_tick && req_pend_reg && i_filter_en;
  wire   err_strobe   = (st_reg == ST_CONV) && i_conv_done;

  // Coefficient banks
  logic signed [COEF_W-1:0] coef_reg [2][NUM_COEF];
  logic [SHIFT_W-1:0]       shift_reg [2];
  logic                     bank_reg;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int b = 0; b < 2; b++)
      begin
        shift_reg[b] <= '0;
        for (int c = 0; c < NUM_COEF; c++)
          coef_reg[b][c] <= '0;
      end
    end
    else if (i_coef_we && i_coef_idx < 3'(NUM_COEF))
    begin
      coef_reg[i_coef_bank][i_coef_idx] <= i_coef_data;
      shift_reg[i_coef_bank]            <= i_coef_shift;
    end
  end
  assign o_bank_active = bank_reg;

  // Filter state
  logic signed [ERR_W-1:0]   e0_reg, e1_reg, e2_reg;
  logic        [STATE_W-1:0] y1a_reg, y2a_reg, ya_reg, yb1_reg, yo_reg;
  wire signed [COEF_W-1:0] k0 = coef_reg[bank_reg][C_B01];
  wire signed [COEF_W-1:0] k1 = coef_reg[bank_reg][C_B11];
  wire signed [COEF_W-1:0] k2 = coef_reg[bank_reg][C_B21];
  wire signed [COEF_W-1:0] ka1 = coef_reg[bank_reg][C_A11];
  wire signed [COEF_W-1:0] ka2 = coef_reg[bank_reg][C_A21];
  wire signed [COEF_W-1:0] kb12 = coef_reg[bank_reg][C_B12];
  wire signed [COEF_W-1:0] ka12 = coef_reg[bank_reg][C_A12];
  // Second-order section, error treated as Q15 (code times 2^11) and scaled up
  wire signed [ACC_W-1:0] acc2 =
      ((ACC_W'(k0 * e0_reg) + ACC_W'(k1 * e1_reg) + ACC_W'(k2 * e2_reg))
        <<< (PU_FRAC - ERR_W + 2))
    + ACC_W'(ka1 * $signed({1'b0, y1a_reg})) + ACC_W'(ka2 * $signed({1'b0, y2a_reg}));
  wire signed [ACC_W-1:0] sec2 = (acc2 >>> COEF_FRAC) <<< shift_reg[bank_reg];
  wire [STATE_W-1:0]      ya_sat = sat_pu(sec2);
  // First-order section
  wire signed [ACC_W-1:0] acc1 =
      ACC_W'($signed({1'b0, ya_reg, {COEF_FRAC{1'b0}}}))
    + ACC_W'(kb12 * $signed({1'b0, y1a_reg}))
    + ACC_W'(ka12 * $signed({1'b0, yb1_reg}));
  wire [STATE_W-1:0] yb_sat = sat_pu(acc1 >>> COEF_FRAC);
  wire [STATE_W-1:0] yo_clamp = (yb_sat < i_clamp_min) ? i_clamp_min :
                                (yb_sat > i_clamp_max) ? i_clamp_max : yb_sat;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg       <= ST_IDLE;
      req_pend_reg <= 1'b0;
      step_reg     <= '0;
      bank_reg     <= 1'b0;
      e0_reg       <= '0;
      e1_reg       <= '0;
      e2_reg       <= '0;
      y1a_reg      <= '0;
      y2a_reg      <= '0;
      ya_reg       <= '0;
      yb1_reg      <= '0;
      yo_reg       <= '0;
    end
    else
    begin
      st_reg <= st_next;
      if (i_sample_req)
        req_pend_reg <= 1'b1;
      else if (o_conv_start)
        req_pend_reg <= 1'b0;
      if (err_strobe)
      begin
        e0_reg   <= err_code;
        step_reg <= '0;
      end
      else if (st_reg == ST_FILT && loop_data_clock_tick)
      begin
        step_reg <= step_reg + 3'h1;
        if (step_reg == 3'h0)
          ya_reg <= ya_sat;
        if (step_reg == 3'h1)
          yo_reg <= yo_clamp;
        if (step_reg == 3'h2)
        begin
          e1_reg  <= e0_reg;
          e2_reg  <= e1_reg;
          y2a_reg <= y1a_reg;
          y1a_reg <= ya_reg;
          yb1_reg <= yo_reg;
        end
      end
      if (st_reg != ST_FILT && st_reg != ST_CONV)
        bank_reg <= i_bank_sel;
    end
  end

  // Command scaling per mode
  wire [DUTY_W-1:0] duty_scaled = scale(yo_reg, i_switching_period);
  wire [DUTY_W-1:0] per_scaled  = scale(yo_reg, i_maximum_period);
  wire [DUTY_W-1:0] fix_duty    = scale(i_fixed_duty_percentage, i_maximum_period);
  wire [DUTY_W-1:0] cmd_duty    = (i_mode == MODE_RESON) ? fix_duty : duty_scaled;
  wire [PRD_W-1:0]  cmd_per     = (i_mode == MODE_RESON) ? per_scaled[DUTY_W-1:FINE_W]
                                                         : i_switching_period;
  wire [CMD_W-1:0]  cmd_word    = {i_mode, cmd_per, cmd_duty};
  wire [CMD_W-1:0]  buf_out;

  elc_skid_buf #(
    .WIDTH (CMD_W)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (st_reg == ST_OUT),
    .o_ready (buf_ready),
    .i_data  (cmd_word),
    .o_valid (o_cmd_valid),
    .i_ready (i_cmd_ready),
    .o_data  (buf_out)
  );

  // Whenever the buffer holds no word, duty rests at the minimum clamp registered one clock earlier, zero out of reset
  logic [DUTY_W-1:0] min_duty_reg;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      min_duty_reg <= '0;
    else
      min_duty_reg <= scale(i_clamp_min, i_switching_period);
  end
  assign o_duty_command     = o_cmd_valid ? buf_out[DUTY_W-1:0] : min_duty_reg;
  assign o_period_command   = buf_out[DUTY_W +: PRD_W];
  assign o_cmd_mode         = elc_mode_t'(buf_out[CMD_W-1 -: 2]);
  assign o_err_sample       = e0_reg;
  assign o_per_unit_command = yo_reg;

  chk_start_on_req: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv_start |-> $past(req_pend_reg) || $past(i_sample_req)) else $error("unrequested start");
  chk_strobe_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    err_strobe |=> e0_reg == $past(err_code)) else $error("error not latched");
  chk_pu_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    yo_reg <= PU_ONE) else $error("per-unit out of range");
  chk_clamp_bounds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == ST_FILT && loop_data_clock_tick && step_reg == 3'h1 && i_clamp_min <= i_clamp_max)
    |=> yo_reg >= $past(i_clamp_min) && yo_reg <= $past(i_clamp_max))
    else $error("clamp violated");
  chk_bank_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == ST_FILT) |=> $stable(bank_reg)) else $error("bank switched mid-sample");
  chk_div_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    loop_data_clock_tick |=> !loop_data_clock_tick [*7] ##1 loop_data_clock_tick) else $error("data clock not div 8");
  chk_resonant_duty: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == ST_OUT && i_mode == MODE_RESON) |-> cmd_duty == DUTY_W'(({{PRD_W{1'b0}},
    i_fixed_duty_percentage} * {{PCT_W{1'b0}}, i_maximum_period}) >> (PU_FRAC - FINE_W)))
    else $error("resonant duty wrong");
  chk_duty_scaling: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg == ST_OUT && i_mode == MODE_DUTY) |-> cmd_duty == DUTY_W'(({{PRD_W{1'b0}},
    yo_reg} * {{STATE_W{1'b0}}, i_switching_period}) >> (PU_FRAC - FINE_W)))
    else $error("duty scaling wrong");
endmodule // elc_loop

// [core/elc_skid_buf.sv]
// Two-entry valid/ready buffer for command words
`timescale 1ns/10ps
module elc_skid_buf #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       cnt_reg;
  wire              push = i_valid & o_ready;
  wire              pop  = o_valid & i_ready;

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= i_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // elc_skid_buf

// [inc/elc_pkg.sv]
// Constants and types shared by the error converter loop compensator
package elc_pkg;
  localparam int ERR_W       = 6;
  localparam int THERM_W     = 63;
  localparam int REF_W       = 10;
  localparam int COEF_W      = 12;
  localparam int COEF_FRAC   = 11;
  localparam int NUM_COEF    = 7;
  localparam int STATE_W     = 16;
  localparam int PU_FRAC     = 15;
  localparam int PRD_W       = 14;
  localparam int DUTY_W      = 18;
  localparam int FINE_W      = 4;
  localparam int PCT_W       = 16;
  localparam int SHIFT_W     = 3;
  localparam int GAIN_W      = 2;
  localparam int ACC_W       = 40;
  localparam int DATA_DIV    = 8;
  localparam int DIV_W       = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
  localparam logic [STATE_W-1:0] PU_ONE = 16'h7FFF;
  // Coefficient index within a bank
  localparam int C_B01 = 0;
  localparam int C_B11 = 1;
  localparam int C_B21 = 2;
  localparam int C_A11 = 3;
  localparam int C_A21 = 4;
  localparam int C_B12 = 5;
  localparam int C_A12 = 6;
  // Front-end gain codes; step is 8 mV shifted right by the code
  localparam logic [GAIN_W-1:0] GAIN_X1 = 2'h0;
  localparam logic [GAIN_W-1:0] GAIN_X2 = 2'h1;
  localparam logic [GAIN_W-1:0] GAIN_X4 = 2'h2;
  localparam logic [GAIN_W-1:0] GAIN_X8 = 2'h3;
  localparam int STEP_MV_X1 = 8;
  localparam int FULL_SCALE_CODES = 64;
  // Command modes
  typedef enum logic [1:0] {
    MODE_DUTY  = 2'h0,
    MODE_RESON = 2'h1,
    MODE_PHASE = 2'h2
  } elc_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_FILT = 4'h4,
    ST_OUT  = 4'h8
  } elc_state_t;
endpackage : elc_pkg

// [verification/elc_conv_model.sv]
// Converter and command sink model at the loop's far side
`timescale 1ns/10ps
module elc_conv_model
  import elc_pkg::*;
#(
  parameter int CONV_DLY = 3
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // Converter side
  input  wire logic                       i_conv_start,
  input  wire logic [5:0]                 i_ones,
  output logic                            o_conv_done,
  output logic [elc_pkg::THERM_W-1:0]     o_conv_therm,
  // Command sink
  input  wire logic                       i_stall,
  input  wire logic                       i_cmd_valid,
  input  wire logic [elc_pkg::DUTY_W-1:0] i_duty,
  input  wire logic [elc_pkg::PRD_W-1:0]  i_period,
  output logic                            o_cmd_ready,
  output int                              o_n_words,
  output logic [elc_pkg::DUTY_W-1:0]      o_last_duty,
  output logic [elc_pkg::PRD_W-1:0]       o_last_prd
);
  import elc_pkg::*;
  int                 cnt;
  logic [THERM_W-1:0] code;
  assign code = ~({THERM_W{1'b1}} << i_ones);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 0;
      o_conv_done <= 1'b0;
      o_conv_therm <= '0;
      o_cmd_ready <= 1'b0;
      o_n_words <= 0;
      o_last_duty <= '0;
      o_last_prd <= '0;
    end
    else
    begin
      o_conv_done <= (cnt == 1);
      // Result only valid with done; otherwise toggling junk
      o_conv_therm <= (cnt == 1) ? code : ~o_conv_therm;
      if (i_conv_start)
        cnt <= CONV_DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
      o_cmd_ready <= !i_stall;
      if (i_cmd_valid && o_cmd_ready)
      begin
        o_n_words <= o_n_words + 1;
        o_last_duty <= i_duty;
        o_last_prd <= i_period;
      end
    end
  end
endmodule // elc_conv_model

// [verification/tb_elc_loop.sv]
// Self-checking bench for the loop compensator
`timescale 1ns/10ps
module tb_elc_loop;
  import elc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, c_start, c_done, en = 1'b1, stall = 1'b0;
  logic [THERM_W-1:0] therm;
  logic [REF_W-1:0] ref_o, ref_i = '0;
  logic [1:0] gain_o, gain_i = 2'h0;
  elc_mode_t mode = MODE_DUTY, mode_o;
  logic [PRD_W-1:0] switching_period = 14'h03E8, mprd = 14'h07D0, prd_o, last_prd;
  logic [15:0] pct = 16'h4000, cmin = 16'h1000, cmax = 16'h6000, pu;
  logic bsel = 1'b0, we = 1'b0, cbank = 1'b0, bact, valid, ready;
  logic [2:0] cidx = 3'h0, csh = 3'h0;
  logic [11:0] cdat = '0;
  logic [5:0] err, ones = 6'h20;
  logic [DUTY_W-1:0] duty, last_duty;
  int n_mismatch = 0, compares = 0, n_words, k;
  always #20 clk = ~clk;
  elc_loop dut (.i_clk(clk), .i_rst_n(rst_n), .i_sample_req(req), .o_conv_start(c_start),
    .i_conv_done(c_done), .i_conv_therm(therm), .o_err_ref(ref_o), .o_afe_gain(gain_o),
    .i_filter_en(en), .i_err_ref(ref_i), .i_afe_gain(gain_i), .i_mode(mode),
    .i_switching_period(switching_period), .i_maximum_period(mprd), .i_fixed_duty_percentage(pct),
    .i_clamp_min(cmin), .i_clamp_max(cmax), .i_bank_sel(bsel), .i_coef_we(we),
    .i_coef_bank(cbank), .i_coef_idx(cidx), .i_coef_data(cdat), .i_coef_shift(csh),
    .o_bank_active(bact), .o_err_sample(err), .o_per_unit_command(pu), .o_cmd_valid(valid),
    .i_cmd_ready(ready), .o_duty_command(duty), .o_period_command(prd_o), .o_cmd_mode(mode_o));
  elc_conv_model model (.i_clk(clk), .i_rst_n(rst_n), .i_conv_start(c_start), .i_ones(ones),
    .o_conv_done(c_done), .o_conv_therm(therm), .i_stall(stall), .i_cmd_valid(valid),
    .i_duty(duty), .i_period(prd_o), .o_cmd_ready(ready), .o_n_words(n_words),
    .o_last_duty(last_duty), .o_last_prd(last_prd));
  function automatic logic [31:0] scl(input logic [31:0] a, input logic [31:0] b, input int s);
    return (a * b) >> s;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wcoef(input logic b, input logic [2:0] i, input logic [11:0] d, input logic [2:0] s);
    @(negedge clk);
    {we, cbank, cidx, cdat, csh} = {1'b1, b, i, d, s};
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic sample(input logic [5:0] o);
    int n0;
    n0 = n_words;
    @(negedge clk);
    ones = o;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    for (int i = 0; i < 300 && n_words == n0; i++)
      @(negedge clk);
    cmp(n_words, n0 + 1);
  endtask
  task automatic t_reset;
    cmp(valid, 1'b0);
    cmp(duty, scl(cmin, switching_period, 11));
    cmp(pu, 16'h0000);
  endtask
  task automatic t_pass;
    for (int g = 0; g < 4; g++)
    begin
      @(negedge clk);
      gain_i = g[1:0];
      ref_i = 10'h3FF - g[9:0];
      #1 cmp(gain_o, g[1:0]);
      cmp(ref_o, 10'h3FF - g[9:0]);
    end
  endtask
  task automatic t_noreq;
    int n0;
    n0 = n_words;
    k = 0;
    repeat (100) @(negedge clk) k += c_start;
    en = 1'b0;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    repeat (100) @(negedge clk) k += c_start;
    cmp(k, 0);
    en = 1'b1;
    repeat (100) @(negedge clk);
    cmp(n_words, n0 + 1);
  endtask
  task automatic t_duty;
    sample(6'h28);
    cmp(err, 6'h08);
    cmp(last_duty, scl(cmin, switching_period, 11));
    sample(6'h00);
    cmp(err, 6'h20);
  endtask
  task automatic t_clamp;
    wcoef(1'b0, 3'h0, 12'h7FF, 3'h7);
    sample(6'h3F);
    cmp(last_duty, scl(cmax, switching_period, 11));
    cmp(pu, cmax);
    sample(6'h00);
    cmp(last_duty, scl(cmin, switching_period, 11));
  endtask
  task automatic t_modes;
    mode = MODE_RESON;
    sample(6'h3F);
    cmp(last_prd, scl(cmax, mprd, 15));
    cmp(last_duty, scl(pct, mprd, 11));
    mode = MODE_PHASE;
    sample(6'h3F);
    cmp(last_duty, scl(cmax, switching_period, 11));
    cmp(last_prd, switching_period);
    mode = MODE_DUTY;
  endtask
  task automatic t_bank;
    int n0;
    @(negedge clk) bsel = 1'b1;
    for (int i = 0; i < 40 && bact !== 1'b1; i++)
      @(negedge clk);
    cmp(bact, 1'b1);
    sample(6'h3F);
    cmp(last_duty, scl(cmin, switching_period, 11));
    n0 = n_words;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    for (int i = 0; i < 20 && c_start !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk) bsel = 1'b0;
    repeat (2) @(negedge clk);
    cmp(bact, 1'b1);
    for (int i = 0; i < 300 && n_words == n0; i++)
      @(negedge clk);
    cmp(n_words, n0 + 1);
    cmp(last_duty, scl(cmin, switching_period, 11));
    cmp(bact, 1'b0);
    sample(6'h3F);
    cmp(last_duty, scl(cmax, switching_period, 11));
  endtask
  task automatic t_stall;
    int n0;
    n0 = n_words;
    stall = 1'b1;
    repeat (2)
    begin
      @(negedge clk) req = 1'b1;
      @(negedge clk) req = 1'b0;
      repeat (150) @(negedge clk);
    end
    cmp(valid, 1'b1);
    cmp(n_words, n0);
    cmp(mode_o, MODE_DUTY);
    cmp(prd_o, switching_period);
    cmp(duty, scl(cmax, switching_period, 11));
    stall = 1'b0;
    repeat (20) @(negedge clk);
    cmp(n_words, n0 + 2);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_pass();
    t_noreq();
    t_duty();
    t_clamp();
    t_modes();
    t_bank();
    t_stall();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule // tb_elc_loop
